// ==== fpu_front_panel.sv ====
`timescale 1ns/1ps
// Contract
// - two green digits show the selected item's index
// - four red digits show values; digital items read On or Off
// - counters alternate between units and thousands
// - eight lamps show inputs, schedule days or current weekday by mode
// - traffic lamp follows data transfer; activity lamp blinks while alive
// - limit and fault lamps follow alarms; battery lamp flashes
// - scheduling lamp lit: shared lamps show clock, day, start, stop, manual
// - with scheduling lamp dark, shared lamps show category and manual
// - a schedule in extension flashes its status on the value digits
// - four open keys select input, digital, output and extension displays
// - hidden keys: setpoint, counter, constants, schedule, clock; advance
// - up raises or chooses On; down lowers or chooses Off
// - auto/manual key toggles the selected module's operation
// - extension key acts only when the selected schedule output is On
// - edit enters and commits; escape leaves and discards
// - edit, auto/manual, up and down need the service plug
// - power-up shows init with all lamps lit, then firmware version
// - stored setup number shows tag and number, then analog input one
// - analog inputs scroll every three seconds; down stops, up resumes
// - download suspends outputs with halt message; restart reruns startup
// - schedule key picks module 1, then 2 to 8 on later presses
// - schedule mode lights its lamp, module number and On/Off status
module fpu_front_panel import fpu_pkg::*; #(
   parameter int DB_CYC = DB_MS * CYC_PER_MS,
   parameter int PHASE_CYC = PHASE_MS * CYC_PER_MS,
   parameter int SCROLL_CYC = SCROLL_MS * CYC_PER_MS,
   parameter int FAST_CYC = FAST_MS * CYC_PER_MS,
   parameter int NET_TMO_CYC = NET_TMO_MS * CYC_PER_MS
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [NKEYS-1:0] keys_raw,
   input wire logic service_plug,
   input wire fpu_item_t item,
   input wire logic [7:0] di_state,
   input wire logic [7:0] sched_days,
   input wire logic [2:0] weekday,
   input wire logic [7:0] sched_out_on,
   input wire logic [7:0] sched_manual,
   input wire logic [7:0] sched_ext,
   input wire logic exc_day_active,
   input wire logic ctrl_manual,
   input wire logic net_traffic,
   input wire logic net_pulse,
   input wire logic ai_alarm,
   input wire logic ext_fault,
   input wire logic battery_low,
   input wire logic download_active,
   input wire logic restart_cmd,
   input wire logic config_valid,
   input wire logic [15:0] config_num,
   input wire logic [15:0] fw_version,
   output logic [1:0][6:0] index_seg,
   output logic [3:0][6:0] value_seg,
   output fpu_lamps_t lamps,
   output fpu_actions_t act,
   output fpu_mode_t mode,
   output logic [2:0] sel,
   output logic [2:0] info_step,
   output logic edit_active,
   output logic outputs_halt
);
   fpu_start_t st_reg;
   fpu_mode_t mode_reg;
   fpu_lamps_t lamps_reg, lamps_next;
   logic [NKEYS-1:0] press, p;
   logic [31:0] phase_cnt_reg, scroll_cnt_reg, fast_cnt_reg, net_cnt_reg;
   logic [2:0] sel_reg, info_reg, slow_cnt_reg;
   logic edit_reg, scroll_reg, fast_ph_reg, slow_ph_reg;
   logic run, phase_done, boot_done, scroll_step, mode_hit;
   fpu_mode_t mode_key;
   logic [5:0][4:0] chars;

   fpu_debounce #(.N(NKEYS), .DB_CYC(DB_CYC)) u_db (
      .sys_clk(sys_clk),
      .rst(rst),
      .raw(keys_raw),
      .press(press)
   );

   fpu_seg_enc #(.N(6)) u_enc (
      .sys_clk(sys_clk),
      .rst(rst),
      .chars(chars),
      .segs({index_seg, value_seg})
   );

   // keys count only once startup has finished and no download runs
   assign run = (st_reg == ST_RUN);
   assign p = press & {NKEYS{run}};
   assign phase_done = (phase_cnt_reg == 32'(PHASE_CYC - 1));
   assign boot_done = phase_done && ((st_reg == ST_CFG) ||
                      (st_reg == ST_VER && !config_valid));

   // startup sequence; a download overrides every other state
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_reg <= ST_INIT;
      end else if (download_active) begin
         st_reg <= ST_HALT;
      end else begin
         unique case (st_reg)
            ST_INIT: if (phase_done) st_reg <= ST_VER;
            ST_VER: if (phase_done) st_reg <= config_valid ? ST_CFG : ST_RUN;
            ST_CFG: if (phase_done) st_reg <= ST_RUN;
            ST_RUN: st_reg <= ST_RUN;
            ST_HALT: if (restart_cmd) st_reg <= ST_INIT;
         endcase
      end
   end

   // per-phase hold timer, restarted on every state change
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         phase_cnt_reg <= '0;
      end else if (run || st_reg == ST_HALT || phase_done ||
                   download_active) begin
         phase_cnt_reg <= '0;
      end else begin
         phase_cnt_reg <= phase_cnt_reg + 32'h1;
      end
   end

   // blink sources: fast for activity, slow for flashing and alternation
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         fast_cnt_reg <= '0;
         fast_ph_reg <= 1'b0;
         slow_cnt_reg <= 3'h0;
         slow_ph_reg <= 1'b0;
      end else if (fast_cnt_reg == 32'(FAST_CYC - 1)) begin
         fast_cnt_reg <= '0;
         fast_ph_reg <= ~fast_ph_reg;
         if (slow_cnt_reg == SLOW_DIV - 3'h1) begin
            slow_cnt_reg <= 3'h0;
            slow_ph_reg <= ~slow_ph_reg;
         end else begin
            slow_cnt_reg <= slow_cnt_reg + 3'h1;
         end
      end else begin
         fast_cnt_reg <= fast_cnt_reg + 32'h1;
      end
   end

   // network liveness: lamp stays dark once pulses stop for the timeout
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         net_cnt_reg <= '0;
      end else if (net_pulse) begin
         net_cnt_reg <= 32'(NET_TMO_CYC);
      end else if (net_cnt_reg != '0) begin
         net_cnt_reg <= net_cnt_reg - 32'h1;
      end
   end

   // display-mode keys
   always_comb begin
      mode_hit = 1'b1;
      mode_key = mode_reg;
      if (p[K_AI]) mode_key = MD_AI;
      else if (p[K_DI]) mode_key = MD_DI;
      else if (p[K_OUT]) mode_key = MD_OUT;
      else if (p[K_EXT]) mode_key = MD_EXT;
      else if (p[K_SETP]) mode_key = MD_SETP;
      else if (p[K_CNT]) mode_key = MD_CNT;
      else if (p[K_CONST]) mode_key = MD_CONST;
      else if (p[K_SCHED]) mode_key = MD_SCHED;
      else if (p[K_CLOCK]) mode_key = MD_CLOCK;
      else mode_hit = 1'b0;
   end

   // mode, item and info step; same mode key again steps the item
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         mode_reg <= MD_AI;
         sel_reg <= SEL_FIRST;
         info_reg <= INFO_STATUS;
      end else if (boot_done) begin
         mode_reg <= MD_AI;
         sel_reg <= SEL_FIRST;
         info_reg <= INFO_STATUS;
      end else if (mode_hit) begin
         mode_reg <= mode_key;
         info_reg <= INFO_STATUS;
         sel_reg <= (mode_key == mode_reg) ? sel_reg + 3'h1 : SEL_FIRST;
      end else if (scroll_step) begin
         sel_reg <= sel_reg + 3'h1;
      end else if (p[K_ADV]) begin
         info_reg <= info_reg + 3'h1;
      end
   end

   // analog input scrolling after startup
   assign scroll_step = run && scroll_reg && mode_reg == MD_AI &&
                        scroll_cnt_reg == 32'(SCROLL_CYC - 1);
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         scroll_reg <= 1'b0;
         scroll_cnt_reg <= '0;
      end else begin
         if (boot_done) begin
            scroll_reg <= 1'b1;
         end else if (mode_hit || (scroll_reg && p[K_DN])) begin
            scroll_reg <= 1'b0;
         end else if (p[K_UP] && mode_reg == MD_AI && !edit_reg) begin
            scroll_reg <= 1'b1;
         end
         if (!scroll_reg || scroll_step || mode_hit) begin
            scroll_cnt_reg <= '0;
         end else begin
            scroll_cnt_reg <= scroll_cnt_reg + 32'h1;
         end
      end
   end

   // edit mode; a mode key, escape or losing the run state drops it
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         edit_reg <= 1'b0;
      end else if (!run || mode_hit || p[K_ESC]) begin
         edit_reg <= 1'b0;
      end else if (p[K_EDIT] && service_plug) begin
         edit_reg <= ~edit_reg;
      end
   end

   // one-cycle action strobes towards the controller data
   always_comb begin
      act = '0;
      // up/down steer the scroll while it owns the analog display
      if (service_plug && !(mode_reg == MD_AI && !edit_reg)) begin
         act.inc = p[K_UP];
         act.dec = p[K_DN];
      end
      act.am_toggle = p[K_AM] && service_plug && (mode_reg == MD_OUT ||
                      mode_reg == MD_SETP || mode_reg == MD_SCHED);
      act.ext_req = p[K_XOVR] && mode_reg == MD_SCHED &&
                    sched_out_on[sel_reg];
      act.edit_enter = p[K_EDIT] && service_plug && !edit_reg;
      act.edit_commit = p[K_EDIT] && service_plug && edit_reg;
      act.edit_abort = p[K_ESC] && edit_reg;
   end

   // character selection for the index and value digits
   always_comb begin
      chars = {6{CH_BLANK}};
      unique case (st_reg)
         ST_INIT: chars = {CH_8, CH_8, CH_I, CH_N, CH_I, CH_T};
         ST_VER: begin
            for (int d = 0; d < 4; d++)
               chars[d] = {1'b0, fw_version[4*d +: 4]};
         end
         ST_CFG: begin
            chars[5] = CH_C;
            chars[4] = CH_F;
            for (int d = 0; d < 4; d++)
               chars[d] = {1'b0, config_num[4*d +: 4]};
         end
         ST_HALT: chars[3:0] = {CH_H, CH_A, CH_L, CH_T};
         ST_RUN: begin
            chars[5] = CH_0;
            chars[4] = {2'h0, sel_reg} + 5'h01;
            for (int d = 0; d < 4; d++) begin
               // counters alternate units and thousands on the slow beat
               chars[d] = {1'b0, (item.is_counter && slow_ph_reg) ?
                  item.thou_bcd[4*d +: 4] : item.value_bcd[4*d +: 4]};
            end
            if ((mode_reg == MD_SCHED && info_reg == INFO_STATUS) ||
                (mode_reg != MD_CLOCK && item.is_digital)) begin
               if ((mode_reg == MD_SCHED) ? sched_out_on[sel_reg]
                                          : item.digital_on) begin
                  chars[3:0] = {CH_BLANK, CH_BLANK, CH_O, CH_N};
               end else begin
                  chars[3:0] = {CH_BLANK, CH_O, CH_F, CH_F};
               end
               if (mode_reg == MD_SCHED && sched_ext[sel_reg] &&
                   !slow_ph_reg) begin
                  chars[3:0] = {4{CH_BLANK}};
               end
            end
         end
      endcase
   end

   // lamp image, registered before it reaches the pins
   always_comb begin
      lamps_next = '0;
      lamps_next.traffic = net_traffic;
      lamps_next.activity = (net_cnt_reg != '0) && fast_ph_reg;
      lamps_next.input_limit_lamp = ai_alarm;
      lamps_next.expansion_fault_lamp = ext_fault;
      lamps_next.battery = battery_low && slow_ph_reg;
      if (run) begin
         lamps_next.const_sel = (mode_reg == MD_CONST);
         lamps_next.counter_sel = (mode_reg == MD_CNT);
         lamps_next.sched = (mode_reg == MD_SCHED ||
                             mode_reg == MD_CLOCK);
         if (mode_reg == MD_SCHED) begin
            lamps_next.day = sched_days;
         end else if (mode_reg == MD_CLOCK) begin
            lamps_next.day = 8'h01 << weekday;
         end else begin
            lamps_next.day = di_state;
         end
         if (lamps_next.sched) begin
            lamps_next.share[SH_CLK_AI] = (mode_reg == MD_CLOCK);
            lamps_next.share[SH_EXC_OUT] = exc_day_active;
            lamps_next.share[SH_START_FUNC] = mode_reg == MD_SCHED &&
               info_reg >= INFO_FIRST_EVENT && !info_reg[0];
            lamps_next.share[SH_STOP_DI] = mode_reg == MD_SCHED &&
               info_reg >= INFO_FIRST_EVENT && info_reg[0];
            // steady for this module, flashing when another is manual
            lamps_next.share[SH_AM] = sched_manual[sel_reg] ||
               (|sched_manual && slow_ph_reg);
         end else begin
            lamps_next.share[SH_CLK_AI] = (mode_reg == MD_AI);
            lamps_next.share[SH_EXC_OUT] = (mode_reg == MD_OUT);
            lamps_next.share[SH_START_FUNC] = (mode_reg == MD_SETP);
            lamps_next.share[SH_STOP_DI] = (mode_reg == MD_DI ||
                                            mode_reg == MD_CNT);
            lamps_next.share[SH_AM] = ctrl_manual;
         end
      end
      if (st_reg == ST_INIT) begin
         lamps_next = '1;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         lamps_reg <= '0;
      end else begin
         lamps_reg <= lamps_next;
      end
   end

   assign lamps = lamps_reg;
   assign mode = mode_reg;
   assign sel = sel_reg;
   assign info_step = info_reg;
   assign edit_active = edit_reg;
   assign outputs_halt = (st_reg == ST_HALT);

   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);

   chk_halt_on_download: assert property (
      download_active |=> outputs_halt [*2])
      else $error("download did not halt outputs");
   chk_halt_message: assert property (
      outputs_halt |=> value_seg == {7'h76, 7'h77, 7'h38, 7'h78})
      else $error("halt message missing");
   chk_init_lamp_test: assert property (
      st_reg == ST_INIT && !download_active |=> lamps == '1)
      else $error("lamp test not complete during init");
   chk_service_gate: assert property (
      !service_plug |-> !(act.inc || act.dec || act.am_toggle ||
                          act.edit_enter || act.edit_commit))
      else $error("service keys acted without plug");
   chk_ext_only_on: assert property (
      act.ext_req |-> mode_reg == MD_SCHED && sched_out_on[sel_reg])
      else $error("extension accepted with output off");
   chk_sched_step: assert property (
      p[K_SCHED] && mode_reg == MD_SCHED && !boot_done |=>
         sel_reg == $past(sel_reg) + 3'h1 && mode_reg == MD_SCHED)
      else $error("schedule key did not step module");
   chk_scroll_stop: assert property (
      scroll_reg && p[K_DN] && !boot_done |=> !scroll_reg ##1 !scroll_step)
      else $error("down key did not stop scrolling");
   chk_edit_commit: assert property (
      edit_reg && p[K_EDIT] && service_plug && !p[K_ESC] && !mode_hit
         |-> act.edit_commit ##1 !edit_reg)
      else $error("edit key did not commit and leave edit");
   chk_boot_to_ai: assert property (
      boot_done && !download_active |=>
         run && mode_reg == MD_AI && sel_reg == SEL_FIRST)
      else $error("startup did not end on analog input one");
   chk_sched_lamp: assert property (
      run && mode_reg == MD_SCHED ##1 st_reg != ST_INIT |-> lamps.sched)
      else $error("scheduling lamp dark in schedule mode");

   cov_boot_done: cover property (boot_done);
   cov_halt_restart: cover property (outputs_halt ##1 st_reg == ST_INIT);
   cov_scroll_step: cover property (scroll_step);
   cov_edit_commit: cover property (act.edit_commit);
endmodule // fpu_front_panel

// ==== fpu_pkg.sv ====
package fpu_pkg;
   // clock and timing figures
   localparam int CLK_HZ = 10_000_000;
   localparam int CYC_PER_MS = CLK_HZ / 1000;
   localparam int DB_MS = 10;
   localparam int PHASE_MS = 1000;
   localparam int SCROLL_MS = 3000;
   localparam int FAST_MS = 100;
   localparam int NET_TMO_MS = 500;
   localparam logic [2:0] SLOW_DIV = 3'h5;

   // key positions in the raw key vector
   localparam int NKEYS = 16;
   localparam int K_AI = 0;
   localparam int K_DI = 1;
   localparam int K_OUT = 2;
   localparam int K_EXT = 3;
   localparam int K_SETP = 4;
   localparam int K_ADV = 5;
   localparam int K_CNT = 6;
   localparam int K_AM = 7;
   localparam int K_UP = 8;
   localparam int K_DN = 9;
   localparam int K_SCHED = 10;
   localparam int K_CLOCK = 11;
   localparam int K_XOVR = 12;
   localparam int K_CONST = 13;
   localparam int K_EDIT = 14;
   localparam int K_ESC = 15;

   // selection and info steps
   localparam logic [2:0] SEL_FIRST = 3'h0;
   localparam logic [2:0] INFO_STATUS = 3'h0;
   localparam logic [2:0] INFO_FIRST_EVENT = 3'h2;

   // shared selection lamps (meaning depends on the scheduling lamp)
   localparam int SH_CLK_AI = 0;
   localparam int SH_EXC_OUT = 1;
   localparam int SH_START_FUNC = 2;
   localparam int SH_STOP_DI = 3;
   localparam int SH_AM = 4;

   // display character codes; 0..9 are the decimal digits
   localparam logic [4:0] CH_8 = 5'h08;
   localparam logic [4:0] CH_0 = 5'h00;
   localparam logic [4:0] CH_BLANK = 5'h0a;
   localparam logic [4:0] CH_O = 5'h0b;
   localparam logic [4:0] CH_N = 5'h0c;
   localparam logic [4:0] CH_F = 5'h0d;
   localparam logic [4:0] CH_I = 5'h0e;
   localparam logic [4:0] CH_T = 5'h0f;
   localparam logic [4:0] CH_H = 5'h10;
   localparam logic [4:0] CH_A = 5'h11;
   localparam logic [4:0] CH_L = 5'h12;
   localparam logic [4:0] CH_C = 5'h13;

   typedef enum logic [3:0] {
      MD_AI, MD_DI, MD_OUT, MD_EXT, MD_SETP, MD_CNT, MD_CONST,
      MD_SCHED, MD_CLOCK
   } fpu_mode_t;

   typedef enum logic [2:0] {
      ST_INIT, ST_VER, ST_CFG, ST_RUN, ST_HALT
   } fpu_start_t;

   typedef struct packed {
      logic [15:0] value_bcd;
      logic [15:0] thou_bcd;
      logic is_digital;
      logic digital_on;
      logic is_counter;
   } fpu_item_t;

   typedef struct packed {
      logic [7:0] day;
      logic traffic;
      logic activity;
      logic input_limit_lamp;
      logic expansion_fault_lamp;
      logic battery;
      logic const_sel;
      logic counter_sel;
      logic sched;
      logic [4:0] share;
   } fpu_lamps_t;

   typedef struct packed {
      logic inc;
      logic dec;
      logic am_toggle;
      logic ext_req;
      logic edit_enter;
      logic edit_commit;
      logic edit_abort;
   } fpu_actions_t;
endpackage

// ==== fpu_debounce.sv ====
`timescale 1ns/1ps
module fpu_debounce import fpu_pkg::*; #(
   parameter int N = NKEYS,
   parameter int DB_CYC = DB_MS * CYC_PER_MS
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [N-1:0] raw,
   output logic [N-1:0] press
);
   localparam int CW = $clog2(DB_CYC + 1);

   // one filter per key; a level must hold DB_CYC cycles to count
   for (genvar k = 0; k < N; k++) begin : g_key
      logic [CW-1:0] cnt_reg;
      logic stable_reg;
      always_ff @(posedge sys_clk or posedge rst) begin
         if (rst) begin
            cnt_reg <= '0;
            stable_reg <= 1'b0;
            press[k] <= 1'b0;
         end else begin
            press[k] <= 1'b0;
            if (raw[k] == stable_reg) begin
               cnt_reg <= '0;
            end else if (cnt_reg == CW'(DB_CYC - 1)) begin
               cnt_reg <= '0;
               stable_reg <= raw[k];
               press[k] <= raw[k];
            end else begin
               cnt_reg <= cnt_reg + 1'b1;
            end
         end
      end
   end
endmodule // fpu_debounce

// ==== fpu_seg_enc.sv ====
`timescale 1ns/1ps
module fpu_seg_enc import fpu_pkg::*; #(
   parameter int N = 6
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [N-1:0][4:0] chars,
   output logic [N-1:0][6:0] segs
);
   // gfedcba, active high; unknown codes show blank
   function automatic logic [6:0] seg_of(input logic [4:0] c);
      case (c)
         5'h00: seg_of = 7'h3f;
         5'h01: seg_of = 7'h06;
         5'h02: seg_of = 7'h5b;
         5'h03: seg_of = 7'h4f;
         5'h04: seg_of = 7'h66;
         5'h05: seg_of = 7'h6d;
         5'h06: seg_of = 7'h7d;
         5'h07: seg_of = 7'h07;
         5'h08: seg_of = 7'h7f;
         5'h09: seg_of = 7'h6f;
         CH_O: seg_of = 7'h5c;
         CH_N: seg_of = 7'h54;
         CH_F: seg_of = 7'h71;
         CH_I: seg_of = 7'h10;
         CH_T: seg_of = 7'h78;
         CH_H: seg_of = 7'h76;
         CH_A: seg_of = 7'h77;
         CH_L: seg_of = 7'h38;
         CH_C: seg_of = 7'h39;
         default: seg_of = 7'h00;
      endcase
   endfunction

   // registered so the digit drivers never see decode glitches
   for (genvar d = 0; d < N; d++) begin : g_dig
      always_ff @(posedge sys_clk or posedge rst) begin
         if (rst) begin
            segs[d] <= 7'h00;
         end else begin
            segs[d] <= seg_of(chars[d]);
         end
      end
   end
endmodule // fpu_seg_enc

// ==== fpu_keypad_model.sv ====
`timescale 1ns/1ps
module fpu_keypad_model import fpu_pkg::*; (
   input wire logic sys_clk,
   input wire logic [3:0] key_idx,
   input wire logic key_down,
   output logic [NKEYS-1:0] keys_raw
);
   logic [1:0] bnc;
   initial begin
      bnc = 2'h0;
      keys_raw = '0;
   end
   // contacts chatter for a few cycles, as a real key does
   always @(posedge sys_clk) begin
      keys_raw <= '0;
      if (key_down) begin
         if (bnc != 2'h3) bnc <= bnc + 2'h1;
         keys_raw[key_idx] <= (bnc == 2'h3) | bnc[0];
      end else begin
         bnc <= 2'h0;
      end
   end
endmodule // fpu_keypad_model

// ==== tb_fpu_front_panel.sv ====
`timescale 1ns/1ps
module tb_fpu_front_panel import fpu_pkg::*;;
   localparam int DB = 4, PH = 20, SC = 30, FC = 5, NT = 50;
   logic sys_clk = 0, rst = 1, plug = 1, kd = 0, rcmd = 0, dl = 0;
   logic alarm = 0, xf = 0, trf = 0, npl = 0, bat = 0, cv = 1;
   logic [3:0] ki = 4'h0;
   logic [7:0] di = 8'h00, son = 8'h00;
   logic [NKEYS-1:0] kraw;
   logic [1:0][6:0] iseg;
   logic [3:0][6:0] vseg;
   fpu_lamps_t lamps;
   fpu_actions_t act, seen = '0;
   fpu_mode_t mode;
   logic [2:0] sel, info, prv;
   logic ed, halt;
   int errors = 0, total_checks = 0;
   int k;
   logic cm = 0, exc = 1;
   logic [2:0] wd = 3'h3;
   logic [7:0] sdays = 8'h5a, sman = 8'h02, sx = 8'h00;
   logic [15:0] fw = 16'h0102, cfg = 16'h0042;
   fpu_item_t itm = {16'h1234, 16'h0005, 3'h0};
   int n1 = 0, n2 = 0, n3 = 0;
   int keys [8] = '{K_DI, K_OUT, K_EXT, K_SETP, K_CNT, K_CONST, K_CLOCK, K_AI};
   fpu_mode_t mds [8] = '{MD_DI, MD_OUT, MD_EXT, MD_SETP, MD_CNT, MD_CONST,
      MD_CLOCK, MD_AI};
   always #50 sys_clk = ~sys_clk;
   // strobes are sticky here so a one-cycle pulse is never missed
   always @(posedge sys_clk) seen <= seen | act;
   fpu_keypad_model pad (.sys_clk(sys_clk), .key_idx(ki), .key_down(kd),
      .keys_raw(kraw));
   fpu_front_panel #(.DB_CYC(DB), .PHASE_CYC(PH), .SCROLL_CYC(SC),
      .FAST_CYC(FC), .NET_TMO_CYC(NT)) dut (.sys_clk(sys_clk), .rst(rst),
      .keys_raw(kraw), .service_plug(plug), .item(itm), .di_state(di),
      .sched_days(sdays), .weekday(wd), .sched_out_on(son),
      .sched_manual(sman), .sched_ext(sx), .exc_day_active(exc),
      .ctrl_manual(cm), .net_traffic(trf), .net_pulse(npl),
      .ai_alarm(alarm), .ext_fault(xf), .battery_low(bat),
      .download_active(dl), .restart_cmd(rcmd), .config_valid(cv),
      .config_num(cfg), .fw_version(fw), .index_seg(iseg),
      .value_seg(vseg), .lamps(lamps), .act(act), .mode(mode), .sel(sel),
      .info_step(info), .edit_active(ed), .outputs_halt(halt));
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #10;
   endtask
   task automatic chk(input string n, input logic [15:0] e,
         input logic [15:0] g);
      total_checks++;
      if (e !== g) begin
         errors++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   // the release must settle too before the next key counts
   task automatic press(input int key);
      seen = '0;
      ki = key[3:0];
      kd = 1;
      cyc(DB + 6);
      kd = 0;
      cyc(DB + 4);
   endtask
   task automatic wait_halt(input logic e);
      for (int i = 0; i < 10 && halt !== e; i++) cyc(1);
      chk("halt", e, halt);
      if (halt !== e) results();
   endtask
   task automatic results();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      cyc(10);
      rst = 0;
      cyc(2);
      chk("lamp test", 1, &lamps);
      chk("index 88", 16'h3fff, iseg);
      chk("init", 7'h78, vseg[0]);
      cyc(28);
      chk("version", 7'h5b, vseg[0]);
      chk("ver index", 0, iseg);
      cyc(20);
      chk("setup tag", 14'h1cf1, iseg);
      chk("setup num", 7'h66, vseg[1]);
      cyc(12);
      chk("mode", MD_AI, mode);
      chk("sel", 0, sel);
      cyc(40);
      chk("scroll", 1, sel);
      chk("value", 7'h66, vseg[0]);
      // a counter shows units and thousands in turn on the slow beat
      itm.is_counter = 1;
      for (k = 0; k < 60; k++) begin
         cyc(1);
         n1 += (vseg[0] == 7'h6d);
      end
      chk("thousands", 1, n1 > 0 && n1 < 60);
      itm.is_counter = 0;
      press(K_DN);
      prv = sel;
      cyc(70);
      chk("stopped", prv, sel);
      press(K_UP);
      cyc(25);
      chk("resumed", prv + 3'h1, sel);
      {alarm, xf, trf, cm, di} = {4'hf, 8'ha5};
      cyc(3);
      chk("ctrl manual", 1, lamps.share[SH_AM]);
      chk("ai lamp", 1, lamps.share[SH_CLK_AI]);
      chk("day", 8'ha5, lamps.day);
      chk("traffic", 1, lamps.traffic);
      chk("limit", 1, lamps.input_limit_lamp);
      chk("fault", 1, lamps.expansion_fault_lamp);
      for (k = 0; k < 8; k++) begin
         press(keys[k]);
         chk("mode key", mds[k], mode);
         if (mds[k] == MD_CLOCK) chk("weekday", 8'h08, lamps.day);
      end
      press(K_SCHED);
      chk("sched", MD_SCHED, mode);
      chk("sched lamp", 1, lamps.sched);
      press(K_SCHED);
      chk("sched sel", 1, sel);
      chk("sched days", 8'h5a, lamps.day);
      chk("own manual", 1, lamps.share[SH_AM]);
      chk("exc day", 1, lamps.share[SH_EXC_OUT]);
      press(K_XOVR);
      chk("ext off", 0, seen.ext_req);
      son = 8'h02;
      press(K_XOVR);
      chk("ext on", 1, seen.ext_req);
      plug = 0;
      press(K_EDIT);
      chk("no plug", 0, ed);
      plug = 1;
      press(K_EDIT);
      chk("edit", 1, ed);
      press(K_UP);
      chk("inc", 1, seen.inc);
      press(K_EDIT);
      chk("commit", 1, seen.edit_commit);
      press(K_EDIT);
      press(K_ESC);
      chk("abort", 1, seen.edit_abort);
      chk("left", 0, ed);
      press(K_AM);
      chk("am", 1, seen.am_toggle);
      // one network pulse, then watch the activity lamp run down while battery and extension keep flashing
      {sx, bat, npl} = {8'h02, 2'h3};
      cyc(1);
      npl = 0;
      n1 = 0;
      for (k = 0; k < 60; k++) begin
         cyc(1);
         n1 += (vseg[0] == 7'h54);
         n2 += lamps.activity;
         n3 += lamps.battery;
      end
      chk("ext flash", 1, n1 > 0 && n1 < 60);
      chk("activity", 1, n2 > 0 && n2 < 60);
      chk("battery", 1, n3 > 0 && n3 < 60);
      chk("net idle", 0, lamps.activity);
      dl = 1;
      wait_halt(1);
      dl = 0;
      cyc(3);
      rcmd = 1;
      cyc(1);
      rcmd = 0;
      wait_halt(0);
      cyc(2);
      chk("rerun", 1, &lamps);
      results();
   end
endmodule // tb_fpu_front_panel
